// ---- src/acsar_map.svh ----
// register indices, reset values and timing counts for the analog channel block
// assumes a 32-bit avalon-mm slave, one register per aligned word
`ifndef ACSAR_MAP_SVH
`define ACSAR_MAP_SVH
// ==================================================================
// register indices (byte address = index * 4)
`define ACSAR_IDX_CFG      5'h00
`define ACSAR_IDX_LO_SIG   5'h01
`define ACSAR_IDX_HI_SIG   5'h02
`define ACSAR_IDX_LO_ENG   5'h03
`define ACSAR_IDX_HI_ENG   5'h04
`define ACSAR_IDX_LO_ALM   5'h05
`define ACSAR_IDX_LL_ALM   5'h06
`define ACSAR_IDX_HI_ALM   5'h07
`define ACSAR_IDX_HH_ALM   5'h08
`define ACSAR_IDX_DEADBAND 5'h09
`define ACSAR_IDX_CAL      5'h0A
`define ACSAR_IDX_RATE     5'h0B
`define ACSAR_IDX_FLT_VAL  5'h0C
`define ACSAR_IDX_PRG_VAL  5'h0D
`define ACSAR_IDX_LO_CLMP  5'h0E
`define ACSAR_IDX_HI_CLMP  5'h0F
`define ACSAR_IDX_CMD      5'h10
`define ACSAR_IDX_STATUS   5'h11
`define ACSAR_IDX_DATA     5'h12
`define ACSAR_IDX_OUT      5'h13
`define ACSAR_IDX_UNLATCH  5'h14
// ==================================================================
// reset values
`define ACSAR_RST_ZERO     16'h0000
`define ACSAR_RST_MAX      16'h7FFF
`define ACSAR_RST_MIN      16'h8000
// ==================================================================
// scale and timing
`define ACSAR_FULL_SCALE   16'h7FFF
`define ACSAR_INIT_TOL     (`ACSAR_FULL_SCALE / 1000)
`define ACSAR_CLK_MHZ      200
`define ACSAR_UPDATE_MS    10
`define ACSAR_UPDATE_CYCLES (`ACSAR_UPDATE_MS * 1000 * `ACSAR_CLK_MHZ)
`define ACSAR_RATE_DIV     100000
`endif

// ---- src/acsar_pkg.sv ----
// types shared by the analog channel block
// assumes acsar_map.svh holds the register and timing constants; the mode encodings are defined here
package acsar_pkg;
  // ==================================================================
  // output modes, gray along prog -> run -> fault
  typedef enum logic [1:0] {
    MODE_PROG  = 2'b00,
    MODE_RUN   = 2'b01,
    MODE_FAULT = 2'b11
  } acsar_mode_e;
  // ==================================================================
  // output configuration word, bit 7 first
  typedef struct packed {
    logic ramp_to_fault_en;
    logic ramp_to_program_en;
    logic ramp_in_run_en;
    logic program_action_sel;
    logic fault_action_sel;
    logic limit_alarm_latch_en;
    logic rate_alarm_latch_en;
    logic hold_for_init;
  } acsar_cfg_s;
  // ==================================================================
  // alarm vector, bit 6 first
  typedef struct packed {
    logic rate_alarm;
    logic high_limit_alarm;
    logic low_limit_alarm;
    logic high_high_process_alarm;
    logic high_process_alarm;
    logic low_low_process_alarm;
    logic low_process_alarm;
  } acsar_alarm_s;
  typedef logic signed [15:0] acsar_val_t;
endpackage

// ---- src/acsar_channel.sv ----
// one analog channel: input scaling and process alarms, output clamp, ramp and modes
// assumes controller state inputs and samples come from logic on i_clock
// Overview of operation
// - scale sample by two-point linear equation
// - add signed calibration offset to scaled data
// - low process alarm below low threshold
// - high process alarm above high threshold
// - low-low alarm below low-low threshold
// - high-high alarm above high-high threshold
// - process alarms release only past deadband
// - hold output until command near present
// - rate alarm latched until unlatch when enabled
// - limit alarms latched until unlatch when enabled
// - fault: hold last or fault value
// - program: hold last or program value
// - run mode ramps toward command when enabled
// - ramp to program value when enabled
// - ramp to fault value when enabled
// - ramp rate is percent full scale per second
// - below low clamp: hold limit, alarm
// - above high clamp: hold limit, alarm
// - unlatch clears once; alarm may reassert
// - unlatch served after sampling completes
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "acsar_map.svh"
module acsar_channel
  import acsar_pkg::*;
#(
  parameter int unsigned P_UPDATE_CYCLES = `ACSAR_UPDATE_CYCLES
) (
  // clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  // avalon-mm slave
  input  wire logic [6:0]   i_avs_address,
  input  wire logic         i_avs_read,
  input  wire logic         i_avs_write,
  input  wire logic [31:0]  i_avs_writedata,
  output logic      [31:0]  o_avs_readdata,
  output logic              o_avs_waitrequest,
  // input sample
  input  wire logic [15:0]  i_sample,
  input  wire logic         i_sample_valid,
  // controller state
  input  wire logic         i_connected,
  input  wire logic         i_run_mode,
  input  wire logic         i_comm_fault,
  // results
  output logic      [15:0]  o_scaled_data,
  output logic      [15:0]  o_out_value,
  output acsar_alarm_s      o_alarms,
  output logic              o_hold_active
);
  // ==================================================================
  // helpers
  function automatic logic signed [16:0] ext17(input logic [15:0] v);
    return {v[15], v};
  endfunction

  function automatic logic [15:0] sat16(input logic signed [33:0] v);
    if (v > 34'sh0_0000_7FFF) begin
      return 16'h7FFF;
    end else if (v < -34'sh0_0000_8000) begin
      return 16'h8000;
    end
    return v[15:0];
  endfunction

  function automatic logic [15:0] cfg_reset(input int i);
    case (i)
      int'(`ACSAR_IDX_HI_SIG), int'(`ACSAR_IDX_HI_ENG), int'(`ACSAR_IDX_HI_ALM),
      int'(`ACSAR_IDX_HH_ALM), int'(`ACSAR_IDX_HI_CLMP): return `ACSAR_RST_MAX;
      int'(`ACSAR_IDX_LO_ALM), int'(`ACSAR_IDX_LL_ALM), int'(`ACSAR_IDX_LO_CLMP): return `ACSAR_RST_MIN;
      default: return `ACSAR_RST_ZERO;
    endcase
  endfunction

  // ==================================================================
  // avalon slave: every access answers on the second cycle
  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic [15:0] cfg_ff [0:16];
  logic [31:0] rd_mux;

  wire       bus_req  = i_avs_read | i_avs_write;
  wire       bus_wr   = i_avs_write & ack_ff;
  wire [4:0] bus_idx  = i_avs_address[6:2];
  wire       cfg_hit  = bus_idx <= `ACSAR_IDX_CMD;
  wire       cmd_wr   = bus_wr & (bus_idx == `ACSAR_IDX_CMD);
  wire       unl_wr   = bus_wr & (bus_idx == `ACSAR_IDX_UNLATCH);

  assign o_avs_waitrequest = bus_req & ~ack_ff;
  assign o_avs_readdata    = rdata_ff;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
      if (i_avs_read & ~ack_ff) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  for (genvar gr = 0; gr <= 16; gr++) begin : g_cfg
    always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
        cfg_ff[gr] <= cfg_reset(gr);
      end else if (bus_wr && bus_idx == 5'(gr)) begin
        cfg_ff[gr] <= i_avs_writedata[15:0];
      end
    end
  end

  // ==================================================================
  // named configuration
  wire acsar_cfg_s  cfg      = acsar_cfg_s'(cfg_ff[`ACSAR_IDX_CFG][7:0]);
  wire acsar_val_t  lo_sig   = cfg_ff[`ACSAR_IDX_LO_SIG];
  wire acsar_val_t  hi_sig   = cfg_ff[`ACSAR_IDX_HI_SIG];
  wire acsar_val_t  lo_eng   = cfg_ff[`ACSAR_IDX_LO_ENG];
  wire acsar_val_t  hi_eng   = cfg_ff[`ACSAR_IDX_HI_ENG];
  wire acsar_val_t  deadband = cfg_ff[`ACSAR_IDX_DEADBAND];
  wire acsar_val_t  cal_ofs  = cfg_ff[`ACSAR_IDX_CAL];
  wire acsar_val_t  lo_clamp = cfg_ff[`ACSAR_IDX_LO_CLMP];
  wire acsar_val_t  hi_clamp = cfg_ff[`ACSAR_IDX_HI_CLMP];
  wire acsar_val_t  out_cmd  = cfg_ff[`ACSAR_IDX_CMD];

  // ==================================================================
  // input scaling, one cycle per sample
  logic [15:0] scaled_ff;
  logic        proc_vld_ff;

  wire signed [16:0] sig_off  = ext17(i_sample) - ext17(lo_sig);
  wire signed [16:0] eng_span = ext17(hi_eng) - ext17(lo_eng);
  wire signed [16:0] sig_raw  = ext17(hi_sig) - ext17(lo_sig);
  // equal signal points would divide by zero; a unit span keeps the data defined
  wire signed [16:0] sig_span = (sig_raw == 17'sh0_0000) ? 17'sh0_0001 : sig_raw;
  wire signed [33:0] scl_prod = sig_off * eng_span;
  wire signed [33:0] scl_quot = scl_prod / 34'(sig_span);
  wire signed [33:0] scl_sum  = scl_quot + 34'(lo_eng) + 34'(cal_ofs);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      scaled_ff   <= 16'h0000;
      proc_vld_ff <= 1'b0;
    end else begin
      proc_vld_ff <= i_sample_valid;
      if (i_sample_valid) begin
        scaled_ff <= sat16(scl_sum);
      end
    end
  end

  // ==================================================================
  // process alarms: 0 low, 1 low-low, 2 high, 3 high-high
  logic [3:0] proc_alm_ff;
  wire signed [16:0] px = ext17(scaled_ff);

  for (genvar gp = 0; gp < 4; gp++) begin : g_proc
    wire signed [16:0] thr  = ext17(cfg_ff[5 + gp]);
    wire signed [16:0] band = ext17(deadband);
    wire trip = (gp < 2) ? (px < thr) : (px > thr);
    wire rel  = (gp < 2) ? (px > thr + band) : (px < thr - band);
    always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
        proc_alm_ff[gp] <= 1'b0;
      end else if (proc_vld_ff && trip) begin
        proc_alm_ff[gp] <= 1'b1;
      end else if (proc_vld_ff && rel) begin
        proc_alm_ff[gp] <= 1'b0;
      end
    end
  end

  // ==================================================================
  // output update tick
  logic [31:0] tick_cnt_ff;
  wire tick = tick_cnt_ff == 32'(P_UPDATE_CYCLES - 1);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_ff <= 32'h0000_0000;
    end else begin
      tick_cnt_ff <= tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
    end
  end

  // ==================================================================
  // mode tracking and hold for initialization
  acsar_mode_e mode_ff;
  logic        conn_ff;
  logic        hold_ff;

  wire acsar_mode_e nxt_mode = i_comm_fault ? MODE_FAULT : (i_run_mode ? MODE_RUN : MODE_PROG);
  wire init_evt = (i_connected & ~conn_ff) | (mode_ff == MODE_PROG && nxt_mode == MODE_RUN)
                | (mode_ff == MODE_FAULT && nxt_mode != MODE_FAULT);
  wire signed [16:0] cmd_gap = ext17(i_avs_writedata[15:0]) - ext17(o_out_value);
  // signed tolerance keeps the window two-sided; an unsigned bound would never match
  wire signed [16:0] init_tol = 17'(`ACSAR_INIT_TOL);
  wire cmd_near = (cmd_gap <= init_tol) && (cmd_gap >= -init_tol);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mode_ff <= MODE_PROG;
      conn_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      conn_ff <= i_connected;
      if (init_evt && cfg.hold_for_init) begin
        hold_ff <= 1'b1;
      end else if (cmd_wr && cmd_near) begin
        hold_ff <= 1'b0;
      end
    end
  end

  // ==================================================================
  // target selection, clamp and ramp
  logic [15:0] out_ff;
  logic [15:0] tgt;
  logic        ramp_on;

  always_comb begin
    unique case (mode_ff)
      MODE_RUN: begin
        tgt     = hold_ff ? out_ff : out_cmd;
        ramp_on = cfg.ramp_in_run_en;
      end
      MODE_PROG: begin
        tgt     = cfg.program_action_sel ? cfg_ff[`ACSAR_IDX_PRG_VAL] : out_ff;
        ramp_on = cfg.ramp_to_program_en;
      end
      MODE_FAULT: begin
        tgt     = cfg.fault_action_sel ? cfg_ff[`ACSAR_IDX_FLT_VAL] : out_ff;
        ramp_on = cfg.ramp_to_fault_en;
      end
      default: begin
        tgt     = out_ff;
        ramp_on = 1'b0;
      end
    endcase
  end

  wire        below  = ext17(tgt) < ext17(lo_clamp);
  wire        above  = ext17(tgt) > ext17(hi_clamp);
  wire [15:0] tgt_c  = below ? lo_clamp : (above ? hi_clamp : tgt);

  // percent of full scale per second times the update interval
  wire [39:0] step_raw = (40'(cfg_ff[`ACSAR_IDX_RATE]) * 40'(`ACSAR_FULL_SCALE) * 40'(`ACSAR_UPDATE_MS))
                       / 40'(`ACSAR_RATE_DIV);
  // a zero step would freeze the ramp; one count is the slowest motion
  wire [15:0] step16 = (step_raw > 40'h00_0000_7FFF) ? 16'h7FFF :
                       ((step_raw == 40'h00_0000_0000) ? 16'h0001 : step_raw[15:0]);
  wire signed [16:0] step17 = {1'b0, step16};
  wire signed [16:0] delta  = ext17(tgt_c) - ext17(out_ff);
  wire        rise_lim = ramp_on && (delta > step17);
  wire        fall_lim = ramp_on && (delta < -step17);
  wire [16:0] up_val   = ext17(out_ff) + step17;
  wire [16:0] dn_val   = ext17(out_ff) - step17;
  wire [15:0] nxt_out  = rise_lim ? up_val[15:0] : (fall_lim ? dn_val[15:0] : tgt_c);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      out_ff <= 16'h0000;
    end else if (tick) begin
      out_ff <= nxt_out;
    end
  end

  // ==================================================================
  // output alarms: 0 rate, 1 low limit, 2 high limit
  logic [2:0] out_alm_ff;
  logic [2:0] unl_pend_ff;

  wire [2:0] alm_cond = {above, below, rise_lim | fall_lim};
  wire [2:0] alm_lat  = {cfg.limit_alarm_latch_en, cfg.limit_alarm_latch_en, cfg.rate_alarm_latch_en};
  // unlatch waits for a quiet cycle so sampling and updates are never delayed
  wire       unl_go   = (|unl_pend_ff) & ~tick & ~i_sample_valid & ~proc_vld_ff;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      unl_pend_ff <= 3'h0;
    end else begin
      unl_pend_ff <= (unl_pend_ff & ~{3{unl_go}}) | (unl_wr ? i_avs_writedata[2:0] : 3'h0);
    end
  end

  for (genvar ga = 0; ga < 3; ga++) begin : g_out_alm
    always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
        out_alm_ff[ga] <= 1'b0;
      end else if (tick) begin
        out_alm_ff[ga] <= alm_cond[ga] | (alm_lat[ga] & out_alm_ff[ga]);
      end else if (unl_go && unl_pend_ff[ga]) begin
        out_alm_ff[ga] <= 1'b0;
      end
    end
  end

  // ==================================================================
  // outputs and read mux
  assign o_scaled_data = scaled_ff;
  assign o_out_value   = out_ff;
  assign o_hold_active = hold_ff;
  assign o_alarms      = acsar_alarm_s'({out_alm_ff[0], out_alm_ff[2], out_alm_ff[1], proc_alm_ff[3],
                                         proc_alm_ff[2], proc_alm_ff[1], proc_alm_ff[0]});
  assign rd_mux = cfg_hit ? {16'h0000, cfg_ff[bus_idx]} :
                  (bus_idx == `ACSAR_IDX_STATUS) ? {22'h00_0000, mode_ff, hold_ff, o_alarms} :
                  (bus_idx == `ACSAR_IDX_DATA)   ? {16'h0000, scaled_ff} :
                  (bus_idx == `ACSAR_IDX_OUT)    ? {16'h0000, out_ff} : 32'h0000_0000;

  // ==================================================================
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  AST_SCALE_HIGH_POINT: assert property (i_sample_valid && i_sample == hi_sig && cal_ofs == 16'h0000
      && hi_sig != lo_sig |=> o_scaled_data == $past(hi_eng))
    else $error("high signal point did not scale to high engineering point");
  AST_CAL_OFFSET: assert property (i_sample_valid && i_sample == lo_sig
      |=> o_scaled_data == sat16(34'($past(lo_eng)) + 34'($past(cal_ofs))))
    else $error("calibration offset not added to scaled data");
  AST_LOW_ALARM: assert property (proc_vld_ff && px < ext17(cfg_ff[5]) |=> o_alarms.low_process_alarm)
    else $error("low process alarm missing");
  AST_HIGH_ALARM: assert property (proc_vld_ff && px > ext17(cfg_ff[7]) |=> o_alarms.high_process_alarm)
    else $error("high process alarm missing");
  AST_LOW_LOW_ALARM: assert property (proc_vld_ff && px < ext17(cfg_ff[6])
      |=> o_alarms.low_low_process_alarm)
    else $error("low-low process alarm missing");
  AST_HIGH_HIGH_ALARM: assert property (proc_vld_ff && px > ext17(cfg_ff[8])
      |=> o_alarms.high_high_process_alarm)
    else $error("high-high process alarm missing");
  AST_DEADBAND_HOLD: assert property (o_alarms.low_process_alarm && proc_vld_ff
      && px <= ext17(cfg_ff[5]) + ext17(deadband) |=> o_alarms.low_process_alarm)
    else $error("low alarm released inside deadband");
  AST_HOLD_FOR_INIT: assert property (hold_ff && mode_ff == MODE_RUN && tick
      && ext17(o_out_value) >= ext17(lo_clamp) && ext17(o_out_value) <= ext17(hi_clamp) |=> $stable(o_out_value))
    else $error("output moved while held for initialization");
  AST_RATE_LATCH: assert property (o_alarms.rate_alarm && cfg.rate_alarm_latch_en && !unl_go
      |=> o_alarms.rate_alarm)
    else $error("latched rate alarm dropped without unlatch");
  AST_FAULT_VALUE: assert property (tick && mode_ff == MODE_FAULT && cfg.fault_action_sel
      && !cfg.ramp_to_fault_en |=> o_out_value == $past(tgt_c))
    else $error("fault value not applied");
  AST_RAMP_STEP: assert property (tick && ramp_on
      |=> (ext17(o_out_value) - ext17($past(o_out_value)) <= $past(step17))
       && (ext17($past(o_out_value)) - ext17(o_out_value) <= $past(step17)))
    else $error("ramp step exceeded");
  AST_LOW_CLAMP: assert property (tick && below && !ramp_on
      |=> o_out_value == $past(lo_clamp) ##0 o_alarms.low_limit_alarm)
    else $error("low clamp or low limit alarm missing");
  AST_UNLATCH_QUIET: assert property (unl_go |-> !tick && !i_sample_valid && !proc_vld_ff
      ##1 (unl_pend_ff == 3'h0 || $past(unl_wr)))
    else $error("unlatch served during sampling or not retired");
endmodule

// ---- dv/acsar_ctl_model.sv ----
// controller model: input samples and connection, run and fault levels for one channel
// assumes the bench calls its tasks from one process clocked by i_clock
`timescale 1ns/1ps
module acsar_ctl_model (
  // clock
  input  wire logic        i_clock,
  // towards the channel
  output logic      [15:0] o_sample,
  output logic             o_sample_valid,
  output logic             o_connected,
  output logic             o_run_mode,
  output logic             o_comm_fault
);
  // ==================================================================
  // idle state: no connection, program mode
  initial begin
    o_sample       = 16'h0000;
    o_sample_valid = 1'b0;
    o_connected    = 1'b0;
    o_run_mode     = 1'b0;
    o_comm_fault   = 1'b0;
  end
  // ==================================================================
  // one-cycle sample pulse; the line is inverted after so a stale value never passes
  task automatic send_sample(input logic [15:0] s);
    @(posedge i_clock);
    o_sample       <= s;
    o_sample_valid <= 1'b1;
    @(posedge i_clock);
    o_sample       <= ~s;
    o_sample_valid <= 1'b0;
  endtask
  // connection, run and fault levels change together at one edge
  task automatic set_state(input logic c, input logic r, input logic f);
    @(posedge i_clock);
    o_connected  <= c;
    o_run_mode   <= r;
    o_comm_fault <= f;
  endtask
endmodule

// ---- dv/analog_channel_scale_alarm_ramp_tb_top.sv ----
// bench for one analog channel: avalon tasks, scaling, alarm, clamp, ramp and mode sequences
// assumes the update interval is cut to 20 clocks so output ticks come quickly
`timescale 1ns/1ps
module analog_channel_scale_alarm_ramp_tb_top;
  // ==================================================================
  // signals
  localparam int P_TICK = 20;
  logic        clk;
  logic        rst;
  logic [6:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] sample;
  logic        sample_valid;
  logic        connected;
  logic        run_mode;
  logic        comm_fault;
  logic [15:0] scaled;
  logic [15:0] out_value;
  logic [6:0]  alarms;
  logic        hold;
  int          err_count;
  int          check_count;
  int          cyc;
  logic [15:0] smp [9] = '{16'h0320, 16'h032A, 16'h03E8, 16'h0366, 16'h0348, 16'h0032, 16'hFFEC,
                           16'h0028, 16'h00A0};
  logic [3:0]  exp [9] = '{4'h0, 4'h4, 4'hC, 4'hC, 4'h4, 4'h1, 4'h3, 4'h3, 4'h0};
  // ==================================================================
  // design and controller model
  acsar_channel #(.P_UPDATE_CYCLES(P_TICK)) dut (
    .i_clock           (clk),
    .i_rst             (rst),
    .i_avs_address     (avs_address),
    .i_avs_read        (avs_read),
    .i_avs_write       (avs_write),
    .i_avs_writedata   (avs_writedata),
    .o_avs_readdata    (avs_readdata),
    .o_avs_waitrequest (avs_waitrequest),
    .i_sample          (sample),
    .i_sample_valid    (sample_valid),
    .i_connected       (connected),
    .i_run_mode        (run_mode),
    .i_comm_fault      (comm_fault),
    .o_scaled_data     (scaled),
    .o_out_value       (out_value),
    .o_alarms          (alarms),
    .o_hold_active     (hold)
  );
  acsar_ctl_model ctl (
    .i_clock        (clk),
    .o_sample       (sample),
    .o_sample_valid (sample_valid),
    .o_connected    (connected),
    .o_run_mode     (run_mode),
    .o_comm_fault   (comm_fault)
  );
  // ==================================================================
  // tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [6:0] a, input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    // read right after the edge, these are the values the slave saw at it
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk("readdata", e, q);
  endtask
  // output changes only on ticks, so five intervals is a generous bound
  task automatic wait_out(input logic [15:0] e);
    int n;
    n = 0;
    @(negedge clk);
    while (out_value !== e && n < 5 * P_TICK) begin
      @(negedge clk);
      n++;
    end
    chk("out_value", e, out_value);
  endtask
  task automatic wait_alm(input int b, input logic v);
    int n;
    n = 0;
    @(negedge clk);
    while (alarms[b] !== v && n < 5 * P_TICK) begin
      @(negedge clk);
      n++;
    end
    chk("alarm bit", v, alarms[b]);
  endtask
  task automatic settle();
    repeat (2 * P_TICK + 5) @(posedge clk);
  endtask
  // ==================================================================
  // clock, reset and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc > 20000) begin
        err_count++;
        end_of_test();
      end
    end
  end
  // ==================================================================
  // test sequence
  initial begin
    rst = 1'b1;
    avs_address = 7'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_count = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(7'h08, 32'h00007FFF);
    rd(7'h38, 32'h00008000);
    rd(7'h00, 32'h0);
    rd(7'h54, 32'h0);
    wr(7'h4C, 16'h1234);
    rd(7'h4C, 32'h0);
    $display("test reset and map done");
    wr(7'h04, 16'h0000);
    wr(7'h08, 16'h03E8);
    wr(7'h0C, 16'h0000);
    wr(7'h10, 16'h0064);
    wr(7'h28, 16'h0005);
    ctl.send_sample(16'h01F4);
    repeat (2) @(negedge clk);
    chk("scaled", 16'h0037, scaled);
    ctl.send_sample(16'hFED4);
    repeat (2) @(negedge clk);
    chk("scaled", 16'hFFE7, scaled);
    ctl.send_sample(16'h0007);
    repeat (2) @(negedge clk);
    rd(7'h48, 32'h00000005);
    $display("test scaling done");
    wr(7'h28, 16'h0000);
    wr(7'h14, 16'h000A);
    wr(7'h18, 16'h0000);
    wr(7'h1C, 16'h0050);
    wr(7'h20, 16'h005A);
    wr(7'h24, 16'h0005);
    for (int i = 0; i < 9; i++) begin
      ctl.send_sample(smp[i]);
      repeat (3) @(negedge clk);
      chk("process alarms", exp[i], alarms[3:0]);
    end
    $display("test process alarms done");
    wr(7'h38, 16'hFC18);
    wr(7'h3C, 16'h03E8);
    wr(7'h2C, 16'h000A);
    wr(7'h00, 16'h0022);
    ctl.set_state(1'b1, 1'b1, 1'b0);
    wr(7'h40, 16'h0064);
    wait_out(16'h0020);
    chk("rate alarm", 1'b1, alarms[6]);
    wait_out(16'h0040);
    wait_out(16'h0060);
    wait_out(16'h0064);
    settle();
    chk("rate alarm", 1'b1, alarms[6]);
    wr(7'h50, 16'h0001);
    wait_alm(6, 1'b0);
    $display("test run ramp done");
    wr(7'h00, 16'h0004);
    wr(7'h40, 16'h07D0);
    wait_out(16'h03E8);
    chk("high limit", 1'b1, alarms[5]);
    wr(7'h40, 16'h0000);
    wait_out(16'h0000);
    chk("high limit", 1'b1, alarms[5]);
    wr(7'h50, 16'h0004);
    wait_alm(5, 1'b0);
    wr(7'h40, 16'hF830);
    wait_out(16'hFC18);
    chk("low limit", 1'b1, alarms[4]);
    wr(7'h50, 16'h0002);
    wait_alm(4, 1'b0);
    wait_alm(4, 1'b1);
    wr(7'h00, 16'h0000);
    wr(7'h40, 16'h0000);
    wait_out(16'h0000);
    wait_alm(4, 1'b0);
    $display("test clamps done");
    wr(7'h34, 16'hFFC0);
    wr(7'h00, 16'h0050);
    ctl.set_state(1'b1, 1'b0, 1'b0);
    wait_out(16'hFFE0);
    wait_out(16'hFFC0);
    wr(7'h00, 16'h0000);
    ctl.set_state(1'b1, 1'b1, 1'b0);
    wr(7'h40, 16'h012C);
    wait_out(16'h012C);
    ctl.set_state(1'b1, 1'b0, 1'b0);
    settle();
    chk("out_value", 16'h012C, out_value);
    $display("test program done");
    wr(7'h30, 16'h00EC);
    wr(7'h00, 16'h0008);
    ctl.set_state(1'b1, 1'b1, 1'b1);
    wait_out(16'h00EC);
    ctl.set_state(1'b1, 1'b1, 1'b0);
    wr(7'h40, 16'h012C);
    wait_out(16'h012C);
    wr(7'h00, 16'h0088);
    ctl.set_state(1'b1, 1'b1, 1'b1);
    wait_out(16'h010C);
    wait_out(16'h00EC);
    wr(7'h00, 16'h0001);
    settle();
    chk("out_value", 16'h00EC, out_value);
    ctl.set_state(1'b1, 1'b1, 1'b0);
    settle();
    chk("hold", 1'b1, hold);
    wr(7'h40, 16'h0190);
    settle();
    chk("out_value", 16'h00EC, out_value);
    chk("hold", 1'b1, hold);
    wr(7'h40, 16'h010C);
    wait_out(16'h010C);
    chk("hold", 1'b0, hold);
    rd(7'h4C, 32'h0000010C);
    $display("test fault and hold done");
    end_of_test();
  end
endmodule
